// ### design/dcff_field_fifo.sv
// Purpose: Serial write and read ports of a 256K x 8 field memory
// Assumes: Port clocks and controls arrive as pins, sampled on core_clk
// Notes:   Pin clocks must be slower than half core_clk
`include "dcff_defines.svh"

module dcff_field_fifo
	import dcff_pkg::*;
(
	// Clock, enable and reset
	input  wire logic                    core_clk,
	input  wire logic                    clk_en,
	input  wire logic                    sys_rst,
	// Write port pins
	input  wire logic                    write_clock,
	input  wire logic                    write_pointer_reset,
	input  wire logic                    write_gate,
	input  wire logic                    input_mask_enable,
	input  wire logic [`DCFF_DATA_W-1:0] data_in_bus,
	// Read port pins
	input  wire logic                    read_clock,
	input  wire logic                    read_pointer_reset,
	input  wire logic                    read_gate,
	input  wire logic                    output_drive_enable,
	// Data output pins
	output logic      [`DCFF_DATA_W-1:0] data_out_bus,
	output logic                         data_out_oe
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic dcff_addr_t dcff_next(input dcff_addr_t a);
		dcff_next = a + `DCFF_ADDR_STEP;
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	dcff_wr_pins_t wr_meta_r;
	dcff_wr_pins_t wr_sync_r;
	dcff_wr_pins_t wr_prev_r;
	dcff_rd_pins_t rd_meta_r;
	dcff_rd_pins_t rd_sync_r;
	dcff_rd_pins_t rd_prev_r;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_meta_r <= '0;
			wr_sync_r <= '0;
			wr_prev_r <= '0;
			rd_meta_r <= '0;
			rd_sync_r <= '0;
			rd_prev_r <= '0;
		end
		else if (clk_en)
		begin
			wr_meta_r <= '{write_clock, write_pointer_reset, write_gate,
				input_mask_enable, data_in_bus};
			wr_sync_r <= wr_meta_r;
			wr_prev_r <= wr_sync_r;
			rd_meta_r <= '{read_clock, read_pointer_reset, read_gate,
				output_drive_enable};
			rd_sync_r <= rd_meta_r;
			rd_prev_r <= rd_sync_r;
		end
	end

	// ------------------------------------------------------------
	// Edge and cycle decode
	// ------------------------------------------------------------
	logic wr_edge;
	logic rd_edge;
	logic wr_rst_cyc;
	logic rd_rst_cyc;
	logic wr_store;
	logic wr_adv;
	logic rd_adv;
	logic wr_rst_seen_r;
	logic rd_rst_seen_r;

	// Ports share nothing but the array
	assign wr_edge    = clk_en & wr_sync_r.clk & ~wr_prev_r.clk;
	assign rd_edge    = clk_en & rd_sync_r.clk & ~rd_prev_r.clk;
	assign wr_rst_cyc = wr_edge & wr_sync_r.rst & ~wr_rst_seen_r;
	assign rd_rst_cyc = rd_edge & rd_sync_r.rst & ~rd_rst_seen_r;
	assign wr_adv     = wr_edge & ~wr_rst_cyc & wr_sync_r.gate;
	assign wr_store   = wr_adv & wr_sync_r.mask;
	assign rd_adv     = rd_edge & ~rd_rst_cyc & rd_sync_r.gate;

	// ------------------------------------------------------------
	// Write port
	// ------------------------------------------------------------
	dcff_addr_t wr_ptr_r;
	dcff_addr_t pend_addr_r;
	dcff_byte_t pend_data_r;
	logic       pend_v_r;
	logic       commit;

	// Held byte goes to the array on the next gated write edge or reset
	assign commit = pend_v_r & (wr_adv | wr_rst_cyc);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_r      <= `DCFF_ADDR_ZERO;
			wr_rst_seen_r <= 1'b0;
			pend_v_r      <= 1'b0;
			pend_addr_r   <= `DCFF_ADDR_ZERO;
			pend_data_r   <= `DCFF_DATA_ZERO;
		end
		else if (wr_edge)
		begin
			wr_rst_seen_r <= wr_sync_r.rst;
			if (wr_rst_cyc)
			begin
				wr_ptr_r <= `DCFF_ADDR_ZERO;
				pend_v_r <= 1'b0;
			end
			else if (wr_adv)
			begin
				wr_ptr_r    <= dcff_next(wr_ptr_r);
				pend_v_r    <= wr_store;
				pend_addr_r <= wr_ptr_r;
				pend_data_r <= wr_sync_r.data;
			end
		end
	end

	// ------------------------------------------------------------
	// Storage: static cells, refresh never contends
	// ------------------------------------------------------------
	dcff_byte_t mem [0:`DCFF_DEPTH-1];

	always_ff @(posedge core_clk)
	begin
		if (commit)
			mem[pend_addr_r] <= pend_data_r;
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	dcff_addr_t rd_ptr_r;
	dcff_byte_t data_out_r;
	logic       data_oe_r;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_ptr_r      <= `DCFF_ADDR_ZERO;
			rd_rst_seen_r <= 1'b0;
			data_out_r    <= `DCFF_DATA_ZERO;
			data_oe_r     <= 1'b0;
		end
		else if (clk_en)
		begin
			data_oe_r <= rd_sync_r.oe;
			if (rd_edge)
			begin
				rd_rst_seen_r <= rd_sync_r.rst;
				if (rd_rst_cyc)
					rd_ptr_r <= `DCFF_ADDR_ZERO;
				else if (rd_adv)
				begin
					data_out_r <= mem[rd_ptr_r];
					rd_ptr_r   <= dcff_next(rd_ptr_r);
				end
			end
		end
	end

	// Registered outputs feed a following device directly
	assign data_out_bus = data_out_r;
	assign data_out_oe  = data_oe_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence wr_reset_edge_s;
		wr_edge && wr_sync_r.rst && !wr_rst_seen_r;
	endsequence

	sequence wr_gated_edge_s;
		wr_edge && !wr_rst_cyc && wr_sync_r.gate;
	endsequence

	wr_ptr_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_reset_edge_s |=> wr_ptr_r == `DCFF_ADDR_ZERO)
		else $error("write pointer not cleared");

	wr_ptr_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_gated_edge_s |=> wr_ptr_r == $past(wr_ptr_r) + `DCFF_ADDR_STEP)
		else $error("write pointer did not advance");

	wr_ptr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_edge && !wr_rst_cyc && !wr_sync_r.gate) |=> $stable(wr_ptr_r))
		else $error("write pointer moved with gate low");

	wr_idle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!wr_edge |=> $stable(wr_ptr_r) && $stable(pend_v_r))
		else $error("write state moved without edge");

	wr_commit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_reset_edge_s and pend_v_r) |=> !pend_v_r ##0
			mem[$past(pend_addr_r)] == $past(pend_data_r))
		else $error("held byte not committed on reset");

	wr_mask_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_gated_edge_s and !wr_sync_r.mask) |=> !pend_v_r)
		else $error("masked byte scheduled for store");

	wr_reset_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_reset_edge_s and wr_sync_r.gate and wr_sync_r.mask) |=> !pend_v_r
			&& wr_ptr_r == `DCFF_ADDR_ZERO)
		else $error("write reset cycle took gate or mask");

	wr_mask_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_gated_edge_s and !wr_sync_r.mask) |=>
			wr_ptr_r == $past(wr_ptr_r) + `DCFF_ADDR_STEP)
		else $error("masked write did not advance pointer");

	wr_store_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_gated_edge_s and wr_sync_r.mask) |=> pend_v_r && pend_addr_r == $past(wr_ptr_r)
			&& pend_data_r == $past(wr_sync_r.data))
		else $error("gated byte not captured");

	wr_commit_next_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_gated_edge_s and pend_v_r) |=>
			mem[$past(pend_addr_r)] == $past(pend_data_r))
		else $error("held byte not committed on next edge");

	rd_ptr_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_edge && rd_sync_r.rst && !rd_rst_seen_r |=> rd_ptr_r == `DCFF_ADDR_ZERO)
		else $error("read pointer not cleared");

	rd_ptr_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_adv |=> rd_ptr_r == $past(rd_ptr_r) + `DCFF_ADDR_STEP
			&& data_out_r == mem[$past(rd_ptr_r)])
		else $error("read did not present byte and advance");

	rd_ptr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_edge && !rd_rst_cyc && !rd_sync_r.gate) |=> $stable(rd_ptr_r))
		else $error("read pointer moved with gate low");

	rd_oe_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en |=> data_out_oe == $past(rd_sync_r.oe))
		else $error("output enable did not follow pin");

	sequence rd_reset_edge_s;
		rd_edge && rd_sync_r.rst && !rd_rst_seen_r;
	endsequence

	sequence rd_gated_edge_s;
		rd_edge && !rd_rst_cyc && rd_sync_r.gate;
	endsequence

	rd_reset_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_reset_edge_s and rd_sync_r.gate) |=> $stable(data_out_r)
			&& rd_ptr_r == `DCFF_ADDR_ZERO)
		else $error("read reset cycle took gate");

	rd_oe_advance_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_gated_edge_s and !rd_sync_r.oe) |=>
			rd_ptr_r == $past(rd_ptr_r) + `DCFF_ADDR_STEP)
		else $error("read pointer held by output enable");

	rd_first_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_gated_edge_s and rd_ptr_r == `DCFF_ADDR_ZERO) |=>
			data_out_r == mem[`DCFF_ADDR_ZERO])
		else $error("first word after reset not presented");

	rd_data_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_edge && !rd_rst_cyc && !rd_sync_r.gate) |=> $stable(data_out_r))
		else $error("read data moved with gate low");

	rd_idle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!rd_edge |=> $stable(rd_ptr_r) && $stable(data_out_r))
		else $error("read state moved without edge");

endmodule

// ### design/dcff_defines.svh
`ifndef DCFF_DEFINES_SVH
`define DCFF_DEFINES_SVH

// Storage geometry: 512 rows by 512 columns of bytes
`define DCFF_ROW_W   9
`define DCFF_COL_W   9
`define DCFF_ADDR_W  18
`define DCFF_DATA_W  8
`define DCFF_DEPTH   262144

// Reset and step values
`define DCFF_ADDR_ZERO  18'h00000
`define DCFF_ADDR_STEP  18'h00001
`define DCFF_DATA_ZERO  8'h00

`endif

// ### design/dcff_pkg.sv
// Purpose: Types shared by the dual clock field FIFO ports
// Assumes: dcff_defines.svh supplies widths
// Notes:   Pin bundles travel as packed structs
`include "dcff_defines.svh"

package dcff_pkg;

	// Write port pin bundle
	typedef struct packed {
		logic                      clk;
		logic                      rst;
		logic                      gate;
		logic                      mask;
		logic [`DCFF_DATA_W-1:0]   data;
	} dcff_wr_pins_t;

	// Read port pin bundle
	typedef struct packed {
		logic clk;
		logic rst;
		logic gate;
		logic oe;
	} dcff_rd_pins_t;

	typedef logic [`DCFF_ADDR_W-1:0] dcff_addr_t;
	typedef logic [`DCFF_DATA_W-1:0] dcff_byte_t;

endpackage

// ### test/dcff_ctrl_model.sv
// Purpose: Video controller model driving write and read pin streams
// Assumes: Pin phases of 4 core_clk each, levels set at start of cycle
// Notes:   Port clocks stand still low between calls
module dcff_ctrl_model
	import dcff_pkg::*;
(
	// Clock
	input  wire logic core_clk,
	// Write pins
	output logic       write_clock,
	output logic       write_pointer_reset,
	output logic       write_gate,
	output logic       input_mask_enable,
	output dcff_byte_t data_in_bus,
	// Read pins
	output logic       read_clock,
	output logic       read_pointer_reset,
	output logic       read_gate,
	output logic       output_drive_enable
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		{write_clock, write_pointer_reset, write_gate, input_mask_enable} = 4'h0;
		{read_clock, read_pointer_reset, read_gate, output_drive_enable} = 4'h0;
		data_in_bus = 8'h00;
	end

	task automatic half();
		repeat (4) @(posedge core_clk);
		#1;
	endtask

	// Gate low leaves lines released, so show inverted data
	task automatic wr_cycle(input logic rst, gate, mask, input dcff_byte_t data);
		{write_pointer_reset, write_gate, input_mask_enable} = {rst, gate, mask};
		data_in_bus = gate ? data : ~data;
		half();
		write_clock = 1'b1;
		half();
		write_clock = 1'b0;
	endtask

	task automatic rd_cycle(input logic rst, gate, oe);
		{read_pointer_reset, read_gate, output_drive_enable} = {rst, gate, oe};
		half();
		read_clock = 1'b1;
		half();
		read_clock = 1'b0;
	endtask
endmodule

// ### test/dcff_field_fifo_tb.sv
// Purpose: Self-checking bench of the field FIFO ports
// Assumes: Controller model sequences the pins
// Notes:   Expected bytes kept in exp_mem
module dcff_field_fifo_tb
	import dcff_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int N = 84;

	logic       core_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       clk_en = 1'b1;
	logic       write_clock, write_pointer_reset, write_gate, input_mask_enable;
	logic       read_clock, read_pointer_reset, read_gate, output_drive_enable;
	dcff_byte_t data_in_bus;
	dcff_byte_t data_out_bus;
	logic       data_out_oe;
	dcff_byte_t exp_mem [0:N-1];
	int         errors = 0;
	int         tests_run = 0;

	always #5 core_clk = ~core_clk;

	dcff_field_fifo i_dut (.core_clk, .clk_en, .sys_rst, .write_clock, .write_pointer_reset,
		.write_gate, .input_mask_enable, .data_in_bus, .read_clock, .read_pointer_reset,
		.read_gate, .output_drive_enable, .data_out_bus, .data_out_oe);
	dcff_ctrl_model i_ctrl (.core_clk, .write_clock, .write_pointer_reset, .write_gate,
		.input_mask_enable, .data_in_bus, .read_clock, .read_pointer_reset, .read_gate,
		.output_drive_enable);

	task automatic chk(input dcff_byte_t got, want, input string m);
		tests_run++;
		if (got !== want)
		begin
			errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict();
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// --------------------------------
	// Write pass, optional mask holes
	// --------------------------------
	task automatic write_pass(input dcff_byte_t key, input logic holes);
		logic m;
		i_ctrl.wr_cycle(1'b1, 1'b1, 1'b1, 8'hff);
		for (int i = 0; i < N; i++)
		begin
			m = !(holes && (i % 7 == 3));
			if (i == 10)
				i_ctrl.wr_cycle(1'b0, 1'b0, 1'b1, 8'h33);
			i_ctrl.wr_cycle(1'b0, 1'b1, m, key ^ i[7:0]);
			if (m)
				exp_mem[i] = key ^ i[7:0];
		end
		i_ctrl.wr_cycle(1'b1, 1'b0, 1'b0, 8'h00);
		repeat (600) i_ctrl.wr_cycle(1'b0, 1'b0, 1'b0, 8'h00);
		repeat (200) @(posedge core_clk);
	endtask

	// --------------------------------
	// Read pass from address zero
	// --------------------------------
	task automatic read_pass();
		logic oe;
		i_ctrl.rd_cycle(1'b1, 1'b1, 1'b0);
		for (int i = 0; i < N; i++)
		begin
			oe = (i % 5) != 2;
			i_ctrl.rd_cycle(1'b0, 1'b1, oe);
			chk(data_out_bus, exp_mem[i], "read data");
			chk({7'h00, data_out_oe}, {7'h00, oe}, "output enable");
			if (i == 20)
			begin
				i_ctrl.rd_cycle(1'b0, 1'b0, 1'b1);
				chk(data_out_bus, exp_mem[i], "gate low hold");
			end
		end
	endtask

	initial
	begin
		repeat (20) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		chk(data_out_bus, 8'h00, "reset data");
		chk({7'h00, data_out_oe}, 8'h00, "reset enable");
		@(posedge core_clk);
		#1;
		for (int i = 0; i < 80; i++)
		begin
			i_ctrl.wr_cycle(1'b0, 1'b1, 1'b1, i[7:0]);
			i_ctrl.rd_cycle(1'b0, 1'b0, 1'b1);
		end
		write_pass(8'h00, 1'b0);
		read_pass();
		write_pass(8'ha5, 1'b1);
		read_pass();
		give_verdict();
	end

	initial
	begin
		#300000;
		errors++;
		give_verdict();
	end
endmodule
